// >>> usb_supply_mode_control.sv
// Notes on behaviour
// - sink mode after reset; source only when selected
// - sink: bus only if wall bad, bus highest
// - off to active on bus needs 4.0V
// - bus limit 100mA or 500mA, default strap
// - active: high current from mode's bit
// - over limit: clamp and raise overcurrent flag
// - override: protection off, flag threshold doubled
// - battery supplements bus above limit
// - good wall supply takes over from bus
// - low power: trickle on, paused when budget under 50mA
// - high power: fast charge trimmed to 500mA
// - charging from bus only in sink mode
// - suspend opens switch, wall or battery selected
// - suspend cleared on reset, uvlo, boot fail
// - source select cleared while power state is off
// - current monitor in both modes
// - overcurrent flag rising edge, read clears
// - overcurrent mask blocks usb interrupt
// - presence changes flag both edges, read clears
// - presence masks suppress the change interrupt, not the flags, reset zero
`timescale 1ns/1ps
module usb_supply_mode_control
	import usc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        config_high_power,
	input  wire usc_presence_t presence,
	input  wire usc_supply_t supply,
	input  wire logic [9:0]  demand_ma,
	input  wire logic [9:0]  charge_req_ma,
	output logic             bus_switch_closed,
	output logic             bus_source_on,
	output logic             bus_protect_en,
	output usc_src_t         power_source,
	output logic             battery_supplement,
	output logic             charge_enable,
	output logic [9:0]       charge_ma,
	output logic             usb_irq,
	output logic             supply_change_irq
);
	logic [15:0]   ctrl;
	logic [15:0]   int_two_mask;
	logic [15:0]   supply_mask;
	usc_pwr_t      pwr_state;
	logic          prev_source_mode;
	logic          strap_done;
	logic          over_flag_in;
	logic          bus_overcurrent_flag;
	logic [2:0]    change_flags;
	logic          clr_two;
	logic          clr_change;
	logic          wb_req;
	logic [7:0]    idx;
	usc_limit_t    lim;
	usc_src_t      next_source;
	logic [9:0]    next_charge;

	logic bus_source_mode_select;
	logic source_mode_high_current;
	logic sink_mode_high_current;
	logic current_limit_override;
	logic suspend;

	assign bus_source_mode_select   = ctrl[BIT_SOURCE_MODE];
	assign source_mode_high_current = ctrl[BIT_SOURCE_HIGH];
	assign sink_mode_high_current   = ctrl[BIT_SINK_HIGH];
	assign current_limit_override   = ctrl[BIT_LIMIT_OVR];
	assign suspend                  = ctrl[BIT_SUSPEND];

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign idx    = wb_adr_i[9:2];

	// bus slave: one wait-free ack cycle after request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= '0;
		end else if (wb_req && !wb_we_i) begin
			unique case (idx)
				REG_POWER_CONTROL:  wb_dat_o <= {16'h0000, ctrl};
				REG_INT_STATUS_TWO: wb_dat_o <= {16'h0000, 5'h00,
					bus_overcurrent_flag, 10'h000};
				REG_SUPPLY_CHANGE:  wb_dat_o <= {16'h0000, change_flags,
					13'h0000};
				REG_INT_TWO_MASK:   wb_dat_o <= {16'h0000, int_two_mask};
				REG_SUPPLY_MASK:    wb_dat_o <= {16'h0000, supply_mask};
				REG_STATE:          wb_dat_o <= {28'h0000000, power_source,
					pwr_state};
				default:            wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// read of a status register clears its flags
	assign clr_two    = wb_req & ~wb_we_i & (idx == REG_INT_STATUS_TWO);
	assign clr_change = wb_req & ~wb_we_i & (idx == REG_SUPPLY_CHANGE);

	// control register with hardware clears
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl <= POWER_CONTROL_RESET;
		end else begin
			if (wb_req && wb_we_i && idx == REG_POWER_CONTROL) begin
				if (wb_sel_i[0]) ctrl[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) ctrl[15:8] <= wb_dat_i[15:8];
			end
			if (!strap_done) begin
				ctrl[BIT_SINK_HIGH] <= config_high_power;
			end
			if (supply.wall_uvlo || supply.boot_fail) begin
				ctrl[BIT_SUSPEND]   <= 1'b0;
				ctrl[BIT_SINK_HIGH] <= 1'b0;
			end
			if (prev_source_mode && pwr_state == USC_OFF) begin
				ctrl[BIT_SOURCE_MODE] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			strap_done       <= 1'b0;
			prev_source_mode <= 1'b0;
		end else begin
			strap_done       <= 1'b1;
			prev_source_mode <= bus_source_mode_select;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			int_two_mask <= MASK_RESET;
			supply_mask  <= MASK_RESET;
		end else if (wb_req && wb_we_i) begin
			if (idx == REG_INT_TWO_MASK) begin
				if (wb_sel_i[0]) int_two_mask[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) int_two_mask[15:8] <= wb_dat_i[15:8];
			end
			if (idx == REG_SUPPLY_MASK) begin
				if (wb_sel_i[0]) supply_mask[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) supply_mask[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	usc_limit_calc u_limit (
		.source_mode (bus_source_mode_select),
		.source_high (source_mode_high_current),
		.sink_high   (sink_mode_high_current),
		.override    (current_limit_override),
		.suspend     (suspend),
		.lim         (lim)
	);

	// off to active needs wall ok, battery present, or 4.0V on bus
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pwr_state <= USC_OFF;
		end else begin
			unique case (pwr_state)
				USC_OFF: if (supply.wall_ok || presence.batt ||
					(presence.bus && supply.bus_mv >= 12'(BOOT_MIN_MV)))
					pwr_state <= USC_ACTIVE;
				USC_ACTIVE: if (!presence.bus && !presence.wall &&
					!presence.batt)
					pwr_state <= USC_OFF;
				default: pwr_state <= USC_OFF;
			endcase
		end
	end

	// source arbitration
	always_comb begin
		next_source = USC_SRC_BATT;
		if (supply.wall_ok) begin
			next_source = USC_SRC_WALL;
		// bus only if wall bad, bus highest
		end else if (!bus_source_mode_select && !suspend && presence.bus &&
			supply.bus_mv >= supply.wall_mv &&
			supply.bus_mv >= supply.batt_mv) begin
			next_source = USC_SRC_BUS;
		end else if (presence.wall && supply.wall_mv >= supply.batt_mv) begin
			next_source = USC_SRC_WALL;
		end
		// suspend leaves battery, or a present wall not below battery, in place of bus
	end

	// charge current budget
	always_comb begin
		// charger runs only from wall or bus
		next_charge = (power_source == USC_SRC_BATT) ? '0 : charge_req_ma;
		if (power_source == USC_SRC_BUS) begin
			// no bus charging in source mode
			if (bus_source_mode_select) begin
				next_charge = '0;
			end else if (demand_ma >= lim.limit_ma) begin
				next_charge = '0;
			end else if ({1'b0, demand_ma} + {1'b0, charge_req_ma} >
				{1'b0, lim.limit_ma}) begin
				next_charge = lim.limit_ma - demand_ma;
			end
			if (lim.limit_ma == 10'(LOW_LIMIT_MA) &&
				next_charge != '0 && next_charge < 10'(TRICKLE_MA))
				next_charge = '0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			power_source       <= USC_SRC_BATT;
			charge_ma          <= '0;
			charge_enable      <= 1'b0;
			battery_supplement <= 1'b0;
			bus_switch_closed  <= 1'b0;
			bus_source_on      <= 1'b0;
			bus_protect_en     <= 1'b1;
		end else begin
			power_source  <= next_source;
			charge_ma     <= next_charge;
			charge_enable <= next_charge != '0;
			battery_supplement <= power_source == USC_SRC_BUS &&
				presence.batt && demand_ma > lim.limit_ma;
			bus_protect_en    <= lim.protect_en;
			bus_switch_closed <= lim.switch_closed;
			bus_source_on     <= lim.source_on;
		end
	end

	assign over_flag_in = lim.switch_closed &&
		({1'b0, demand_ma} > lim.flag_ma);

	usc_edge_flags #(.N(1), .BOTH(1'b0)) u_over (
		.sys_clk (sys_clk),
		.rst     (rst),
		.trig    (over_flag_in),
		.clear   (clr_two),
		.flag    (bus_overcurrent_flag)
	);

	usc_edge_flags #(.N(3), .BOTH(1'b1)) u_change (
		.sys_clk (sys_clk),
		.rst     (rst),
		.trig    ({presence.bus, presence.wall, presence.batt}),
		.clear   (clr_change),
		.flag    (change_flags)
	);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			usb_irq           <= 1'b0;
			supply_change_irq <= 1'b0;
		end else begin
			usb_irq <= bus_overcurrent_flag & ~int_two_mask[BIT_OVERCURRENT];
			supply_change_irq <= |(change_flags &
				~supply_mask[BIT_BUS_CHANGE:BIT_BATT_CHANGE]);
		end
	end

	property p_ack_one;
		@(posedge sys_clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held");

	property p_source_reset;
		@(posedge sys_clk) disable iff (rst)
		!bus_source_mode_select |=> !bus_source_on;
	endproperty
	a_source_reset: assert property (p_source_reset)
		else $error("source on in sink mode");

	property p_boot;
		@(posedge sys_clk) disable iff (rst)
		(pwr_state == USC_OFF && !supply.wall_ok && !presence.batt &&
		 supply.bus_mv < 12'(BOOT_MIN_MV)) |=> pwr_state == USC_OFF;
	endproperty
	a_boot: assert property (p_boot)
		else $error("boot on low bus");

	property p_wall_pref;
		@(posedge sys_clk) disable iff (rst)
		supply.wall_ok |=> power_source == USC_SRC_WALL;
	endproperty
	a_wall_pref: assert property (p_wall_pref)
		else $error("wall not preferred");

	property p_no_src_charge;
		@(posedge sys_clk) disable iff (rst)
		(power_source == USC_SRC_BUS && bus_source_mode_select)
			|=> charge_ma == '0;
	endproperty
	a_no_src_charge: assert property (p_no_src_charge)
		else $error("charging in source mode");

	property p_budget;
		@(posedge sys_clk) disable iff (rst)
		(power_source == USC_SRC_BUS && demand_ma < lim.limit_ma)
			|=> charge_ma <= $past(lim.limit_ma) - $past(demand_ma);
	endproperty
	a_budget: assert property (p_budget)
		else $error("charge over budget");

	property p_over_set;
		@(posedge sys_clk) disable iff (rst)
		$rose(over_flag_in) |=> bus_overcurrent_flag;
	endproperty
	a_over_set: assert property (p_over_set)
		else $error("overcurrent flag not set");

	property p_usb_mask;
		@(posedge sys_clk) disable iff (rst)
		int_two_mask[BIT_OVERCURRENT] [*2] |-> !usb_irq;
	endproperty
	a_usb_mask: assert property (p_usb_mask)
		else $error("masked irq raised");

	property p_change;
		@(posedge sys_clk) disable iff (rst)
		$changed(presence.wall) |=> change_flags[1];
	endproperty
	a_change: assert property (p_change)
		else $error("wall change missed");

	property p_irq_level;
		@(posedge sys_clk) disable iff (rst)
		(change_flags != 3'b000 && supply_mask == 16'h0000)
			|=> supply_change_irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("supply irq missing");

endmodule : usb_supply_mode_control

// >>> usb_supply_mode_control_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module usb_supply_mode_control_test
	import usc_pkg::*;
;
	logic          sys_clk = 1'b0;
	logic          rst = 1'b1;
	logic          cfg = 1'b0;
	logic [31:0]   wb_adr = 32'h0;
	logic [31:0]   wb_dat = 32'h0;
	logic          wb_we = 1'b0;
	logic          wb_cyc = 1'b0;
	logic          wb_stb = 1'b0;
	logic [31:0]   wb_dat_o;
	logic          wb_ack_o;
	logic [2:0]    pres = 3'b101;
	logic          wall_ok = 1'b0;
	logic          wall_uvlo = 1'b0;
	logic          boot_fail = 1'b0;
	logic [9:0]    load = 10'h000;
	logic          bus_p;
	logic [11:0]   bus_mv;
	logic [9:0]    demand;
	usc_presence_t presence;
	usc_supply_t   supply;
	logic          sw_closed, src_on, prot_en, supp, chg_en, usb_irq, sc_irq;
	logic [9:0]    chg_ma;
	usc_src_t      psrc;
	logic [15:0]   rd;
	int            fail_count = 0;
	int            cmp_count = 0;
	int            seed = 32'h8BDC;
	logic [9:0]    d;

	assign presence = {bus_p, pres[1], pres[0]};
	assign supply = {bus_mv, 12'hDAC, 12'hE74, wall_ok, wall_uvlo, boot_fail};

	always #5 sys_clk = ~sys_clk;

	usc_bus_partner part_u (.sys_clk(sys_clk), .attached(pres[2]),
		.load_ma(load), .bus_present(bus_p), .bus_mv(bus_mv),
		.demand_ma(demand));

	usb_supply_mode_control dut_u (.sys_clk(sys_clk), .rst(rst),
		.wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'h3),
		.wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.config_high_power(cfg), .presence(presence), .supply(supply),
		.demand_ma(demand), .charge_req_ma(10'h064),
		.bus_switch_closed(sw_closed), .bus_source_on(src_on),
		.bus_protect_en(prot_en), .power_source(psrc),
		.battery_supplement(supp), .charge_enable(chg_en),
		.charge_ma(chg_ma), .usb_irq(usb_irq),
		.supply_change_irq(sc_irq));

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	task automatic wb_xfer(input logic we, input logic [7:0] idx,
		input logic [15:0] wd);
		@(posedge sys_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= {22'h0, idx, 2'b00};
		wb_dat <= {16'h0, wd};
		do begin
			@(posedge sys_clk);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o[15:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
	endtask : wb_xfer

	// clear flag, raise demand, check flag and interrupt line
	task automatic oc_try(input logic [9:0] dm, input logic ex,
		input logic msk);
		load <= 10'h000;
		tick(4);
		wb_xfer(1'b0, REG_INT_STATUS_TWO, 16'h0);
		load <= dm;
		tick(5);
		`CHK(usb_irq, ex & ~msk)
		wb_xfer(1'b0, REG_INT_STATUS_TWO, 16'h0);
		`CHK(rd[BIT_OVERCURRENT], ex)
		tick(2);
		`CHK(usb_irq, 1'b0)
	endtask : oc_try

	task automatic complete_run();
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	initial begin
		#200000;
		fail_count++;
		complete_run();
	end

	initial begin
		tick(8);
		rst <= 1'b0;
		tick(2);
		wb_xfer(1'b0, REG_POWER_CONTROL, 16'h0);
		`CHK(rd, POWER_CONTROL_RESET)
		wb_xfer(1'b0, REG_INT_TWO_MASK, 16'h0);
		`CHK(rd[BIT_OVERCURRENT], 1'b0)
		wb_xfer(1'b0, REG_SUPPLY_MASK, 16'h0);
		`CHK(rd[15:13], 3'b000)
		wb_xfer(1'b0, 8'h3C, 16'h0);
		`CHK(rd, 16'h0000)
		tick(4);
		`CHK(psrc, USC_SRC_BUS)
		wall_ok <= 1'b1;
		tick(4);
		`CHK(psrc, USC_SRC_WALL)
		wall_ok <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			// host suspends bus while idle
			wb_xfer(1'b1, REG_POWER_CONTROL, 16'h4000);
			tick(4);
			`CHK(sw_closed, 1'b0)
			`CHK(psrc, USC_SRC_BATT)
			wall_uvlo <= (k == 0);
			boot_fail <= (k == 1);
			tick(2);
			wall_uvlo <= 1'b0;
			boot_fail <= 1'b0;
			wb_xfer(1'b0, REG_POWER_CONTROL, 16'h0);
			`CHK(rd[BIT_SUSPEND], 1'b0)
		end
		tick(3);
		`CHK(sw_closed, 1'b1)
		oc_try(10'h065, 1'b1, 1'b0);
		oc_try(10'h064, 1'b0, 1'b0);
		for (int i = 0; i < 6; i++) begin
			d = $random(seed);
			oc_try(d, d > 10'h064, 1'b0);
		end
		wb_xfer(1'b1, REG_INT_TWO_MASK, 16'h0400);
		oc_try(10'h0C8, 1'b1, 1'b1);
		wb_xfer(1'b1, REG_INT_TWO_MASK, 16'h0000);
		wb_xfer(1'b1, REG_POWER_CONTROL, 16'h0200);
		oc_try(10'h1F4, 1'b0, 1'b0);
		oc_try(10'h1F5, 1'b1, 1'b0);
		`CHK(supp, 1'b1)
		`CHK(chg_ma, 10'h000)
		load <= 10'h1C2;
		tick(4);
		`CHK(supp, 1'b0)
		`CHK(chg_ma, 10'h032)
		wb_xfer(1'b1, REG_POWER_CONTROL, 16'h0300);
		tick(3);
		`CHK(prot_en, 1'b0)
		oc_try(10'h3E8, 1'b0, 1'b0);
		oc_try(10'h3E9, 1'b1, 1'b0);
		wb_xfer(1'b1, REG_POWER_CONTROL, 16'h2000);
		tick(3);
		`CHK(src_on, 1'b1)
		`CHK(chg_en, 1'b0)
		`CHK(prot_en, 1'b1)
		oc_try(10'h0C8, 1'b1, 1'b0);
		load <= 10'h000;
		for (int i = 0; i < 3; i++) begin
			for (int e = 0; e < 2; e++) begin
				wb_xfer(1'b0, REG_SUPPLY_CHANGE, 16'h0);
				pres[2 - i] <= ~pres[2 - i];
				tick(5);
				`CHK(sc_irq, 1'b1)
				wb_xfer(1'b0, REG_SUPPLY_CHANGE, 16'h0);
				`CHK(rd[15:13], 3'b100 >> i)
			end
		end
		wb_xfer(1'b1, REG_SUPPLY_MASK, 16'hE000);
		pres <= ~pres;
		tick(5);
		`CHK(sc_irq, 1'b0)
		// mid-run reset with the high-power strap set
		cfg <= 1'b1;
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(2);
		wb_xfer(1'b0, REG_POWER_CONTROL, 16'h0);
		`CHK(rd[BIT_SINK_HIGH], 1'b1)
		`CHK(rd[BIT_SOURCE_MODE], 1'b0)
		`CHK(rd[BIT_SUSPEND], 1'b0)
		complete_run();
	end
endmodule : usb_supply_mode_control_test

// >>> usc_bus_partner.sv
`timescale 1ns/1ps
module usc_bus_partner
	import usc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       attached,
	input  wire logic [9:0] load_ma,
	output logic            bus_present,
	output logic [11:0]     bus_mv,
	output logic [9:0]      demand_ma
);
	always_ff @(posedge sys_clk) begin
		bus_present <= attached;
		bus_mv      <= attached ? 12'hFA0 : 12'h000;
		demand_ma   <= attached ? load_ma : 10'h000;
	end
endmodule : usc_bus_partner

// >>> usc_edge_flags.sv
`timescale 1ns/1ps
module usc_edge_flags
	import usc_pkg::*;
#(
	parameter int N    = 3,
	parameter bit BOTH = 1'b1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [N-1:0] trig,
	input  wire logic         clear,
	output logic      [N-1:0] flag
);
	logic [N-1:0] prev;

	// no reset: prev tracks trig through reset, so release makes no edge
	always_ff @(posedge sys_clk) begin
		prev <= trig;
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			logic ev;
			assign ev = BOTH ? (trig[i] ^ prev[i]) : (trig[i] & ~prev[i]);
			// set wins over read-clear
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					flag[i] <= 1'b0;
				end else if (ev) begin
					flag[i] <= 1'b1;
				end else if (clear) begin
					flag[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : usc_edge_flags

// >>> usc_limit_calc.sv
`timescale 1ns/1ps
module usc_limit_calc
	import usc_pkg::*;
(
	input  wire logic       source_mode,
	input  wire logic       source_high,
	input  wire logic       sink_high,
	input  wire logic       override,
	input  wire logic       suspend,
	output usc_limit_t      lim
);
	logic high;

	always_comb begin
		high              = source_mode ? source_high : sink_high;
		lim.limit_ma      = high ? 10'(HIGH_LIMIT_MA) : 10'(LOW_LIMIT_MA);
		lim.protect_en    = ~override;
		lim.flag_ma       = override ? 11'({1'b0, lim.limit_ma} * 11'(OVERRIDE_FACTOR))
		                             : {1'b0, lim.limit_ma};
		lim.switch_closed = ~suspend;
		lim.source_on     = source_mode & ~suspend;
	end
endmodule : usc_limit_calc

// >>> usc_pkg.sv
package usc_pkg;

	// register indices (byte address is four times the index)
	localparam logic [7:0] REG_POWER_CONTROL  = 8'h04;
	localparam logic [7:0] REG_INT_STATUS_TWO = 8'h1A;
	localparam logic [7:0] REG_SUPPLY_CHANGE  = 8'h1F;
	localparam logic [7:0] REG_INT_TWO_MASK   = 8'h22;
	localparam logic [7:0] REG_SUPPLY_MASK    = 8'h27;
	localparam logic [7:0] REG_STATE          = 8'h40;

	// usb_power_control fields
	localparam int BIT_SUSPEND      = 14;
	localparam int BIT_SOURCE_MODE  = 13;
	localparam int BIT_SOURCE_HIGH  = 11;
	localparam int BIT_SINK_HIGH    = 9;
	localparam int BIT_LIMIT_OVR    = 8;
	// status and mask fields
	localparam int BIT_OVERCURRENT  = 10;
	localparam int BIT_BUS_CHANGE   = 15;
	localparam int BIT_WALL_CHANGE  = 14;
	localparam int BIT_BATT_CHANGE  = 13;

	localparam logic [15:0] POWER_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET          = 16'h0000;

	// usb thresholds in millivolts and milliamps
	localparam int BOOT_MIN_MV       = 4000;
	localparam int LOW_LIMIT_MA      = 100;
	localparam int HIGH_LIMIT_MA     = 500;
	localparam int OVERRIDE_FACTOR   = 2;
	localparam int TRICKLE_MA        = 50;

	typedef enum logic [1:0] {
		USC_SRC_BATT = 2'b00,
		USC_SRC_WALL = 2'b01,
		USC_SRC_BUS  = 2'b10
	} usc_src_t;

	typedef enum logic [1:0] {
		USC_OFF    = 2'b00,
		USC_ACTIVE = 2'b01
	} usc_pwr_t;

	typedef struct packed {
		logic bus;
		logic wall;
		logic batt;
	} usc_presence_t;

	typedef struct packed {
		logic [11:0] bus_mv;
		logic [11:0] wall_mv;
		logic [11:0] batt_mv;
		logic        wall_ok;
		logic        wall_uvlo;
		logic        boot_fail;
	} usc_supply_t;

	typedef struct packed {
		logic        switch_closed;
		logic        protect_en;
		logic        source_on;
		logic [9:0]  limit_ma;
		logic [10:0] flag_ma;
	} usc_limit_t;

endpackage : usc_pkg
